/* spsh_pkg.sv */
// spsh_pkg.sv: shared constants and types for the serial half control block
package spsh_pkg;

	// ----------------------------------------
	// register byte offsets on the apb bus
	// ----------------------------------------
	localparam logic [7:0] SPSH_CTL_OFF  = 8'h00; // serial_half_a_control
	localparam logic [7:0] SPSH_DIV_OFF  = 8'h04; // sync interval divisor
	localparam logic [7:0] SPSH_TX_OFF   = 8'h08; // transmit word
	localparam logic [7:0] SPSH_RX_OFF   = 8'h0C; // receive word
	localparam logic [7:0] SPSH_STAT_OFF = 8'h10; // status

	// ----------------------------------------
	// control field positions
	// ----------------------------------------
	localparam int SPSH_GCLK_POS  = 21; // gated_clock_on
	localparam int SPSH_ERRM_POS  = 20; // sync_error_response
	localparam int SPSH_WORD_ASSEMBLY_MODE_LO   = 18; // word_assembly_mode, two bits
	localparam int SPSH_LATE_POS  = 17; // late_sync_select
	localparam int SPSH_LOW_POS   = 16; // sync_polarity_low
	localparam int SPSH_INDEP_POS = 15; // sync_independent_of_data
	localparam int SPSH_INT_POS   = 14; // sync_source_internal

	// ----------------------------------------
	// status field positions
	// ----------------------------------------
	localparam int SPSH_ERR_POS   = 0; // sticky sync error, write one clears
	localparam int SPSH_TXRDY_POS = 1; // transmit word may be written
	localparam int SPSH_RXVAL_POS = 2; // receive word waiting

	// ----------------------------------------
	// reset values and masks
	// ----------------------------------------
	localparam logic [31:0] SPSH_CTL_MASK = 32'h003FC000; // implemented control bits
	localparam logic [31:0] SPSH_CTL_RST  = 32'h00000000;
	localparam logic [7:0]  SPSH_DIV_RST  = 8'h20;        // bit periods per sync slot

	// ----------------------------------------
	// word assembly codes and unit counts
	// ----------------------------------------
	localparam logic [1:0] SPSH_WORD_ASSEMBLY_MODE_OFF = 2'h0;
	localparam logic [1:0] SPSH_WORD_ASSEMBLY_MODE_8   = 2'h1;
	localparam logic [1:0] SPSH_WORD_ASSEMBLY_MODE_16  = 2'h2;
	localparam logic [4:0] SPSH_LAST8    = 5'h07; // last bit index of a byte unit
	localparam logic [4:0] SPSH_LAST16   = 5'h0F;
	localparam logic [4:0] SPSH_LAST32   = 5'h1F;

	// configuration carried into the link domain
	typedef struct packed {
		logic       gated;    // clock only inside frames
		logic       discard;  // drop receive data on sync error
		logic [1:0] word_assembly_mode;     // word assembly mode
		logic       late;     // sync during first bit
		logic       low;      // sync active low
		logic       indep;    // sync regardless of data
		logic       internal; // sync made here
		logic [7:0] divisor;  // bit periods per sync slot
	} spsh_cfg_t;

	// link sequencer states
	typedef enum logic [1:0] {SPSH_IDLE, SPSH_LEAD, SPSH_SHIFT} spsh_state_t;

endpackage : spsh_pkg

/* spsh_sync.sv */
// spsh_sync.sv: three stage synchroniser that accepts a change once stages two and three agree
module spsh_sync #(
	parameter int W = 1
) (
	// clock and reset of the receiving domain
	input  wire logic         clock,
	input  wire logic         rst_n,
	// foreign input and its settled copy
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q; // first stage, read by the second only
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_q;  // settled value

	// stage chain; the held value moves only when the last two stages match
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_q  <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q_q  <= (s2_q == s3_q) ? s3_q : q_q;
		end
	end

	assign q = q_q;

endmodule : spsh_sync

/* spsh_word_xfer.sv */
// spsh_word_xfer.sv: toggle handshake that moves one 32-bit word between two clocks
module spsh_word_xfer (
	// clocks and reset
	input  wire logic        src_clk,
	input  wire logic        dst_clk,
	input  wire logic        rst_n,
	// filling side
	input  wire logic        src_valid,
	output logic             src_ready,
	input  wire logic [31:0] src_data,
	// draining side
	output logic             dst_valid,
	input  wire logic        dst_ready,
	output logic [31:0]      dst_data
);

	logic        req_q;  // source toggle
	logic        busy_q; // word in flight
	logic [31:0] hold_q; // stable while busy
	logic        ack_q;  // destination toggle
	logic        val_q;  // word offered downstream
	logic [31:0] data_q;
	logic        ack_s;  // ack seen in source domain
	logic        req_s;  // req seen in destination domain

	// toggles cross through the synchroniser
	spsh_sync #(.W(1)) u_ack (.clock(src_clk), .rst_n(rst_n), .d(ack_q), .q(ack_s));
	spsh_sync #(.W(1)) u_req (.clock(dst_clk), .rst_n(rst_n), .d(req_q), .q(req_s));

	// source: capture a word, then wait until the ack toggle comes back
	always_ff @(posedge src_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_q  <= 1'b0;
			busy_q <= 1'b0;
			hold_q <= 32'h00000000;
		end else if (src_valid && !busy_q) begin
			req_q  <= ~req_q;
			busy_q <= 1'b1;
			hold_q <= src_data;
		end else if (busy_q && (ack_s == req_q)) begin
			busy_q <= 1'b0;
		end
	end

	// destination: offer the word until taken, then acknowledge
	always_ff @(posedge dst_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q  <= 1'b0;
			val_q  <= 1'b0;
			data_q <= 32'h00000000;
		end else if (!val_q && (req_s != ack_q)) begin
			val_q  <= 1'b1;
			data_q <= hold_q;
		end else if (val_q && dst_ready) begin
			val_q  <= 1'b0;
			ack_q  <= ~ack_q;
		end
	end

	assign src_ready = ~busy_q;
	assign dst_valid = val_q;
	assign dst_data  = data_q;

endmodule : spsh_word_xfer

/* spsh_half_ctl.sv */
// spsh_half_ctl.sv: control fields, framing and word assembly for one serial port half
//
// The APB slave port and the register offsets are this design's own decisions.
module spsh_half_ctl
	import spsh_pkg::*;
(
	// system clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial link
	input  wire logic        link_clk,
	output logic             ser_clk_o,
	input  wire logic        sync_i,
	output logic             sync_o,
	output logic             sync_oe_n,
	input  wire logic        data_i,
	output logic             data_o
);

	// ----------------------------------------
	// helper functions
	// ----------------------------------------

	// last bit index of one serial unit
	function automatic logic [4:0] unit_last(input logic [1:0] pk);
		case (pk)
			SPSH_WORD_ASSEMBLY_MODE_8:  unit_last = SPSH_LAST8;
			SPSH_WORD_ASSEMBLY_MODE_16: unit_last = SPSH_LAST16;
			default:      unit_last = SPSH_LAST32; // off, and the unused code
		endcase
	endfunction : unit_last

	// index of the last unit within a word
	function automatic logic [1:0] idx_last(input logic [1:0] pk);
		case (pk)
			SPSH_WORD_ASSEMBLY_MODE_8:  idx_last = 2'h3;
			SPSH_WORD_ASSEMBLY_MODE_16: idx_last = 2'h1;
			default:      idx_last = 2'h0;
		endcase
	endfunction : idx_last

	// pick one unit out of a word, left justified, first unit from the low end
	function automatic logic [31:0] unit_sel(input logic [31:0] w, input logic [1:0] pk,
	                                          input logic [1:0] ix);
		case (pk)
			SPSH_WORD_ASSEMBLY_MODE_8:  unit_sel = {w[{ix, 3'h0} +: 8], 24'h000000};
			SPSH_WORD_ASSEMBLY_MODE_16: unit_sel = {w[{ix[0], 4'h0} +: 16], 16'h0000};
			default:      unit_sel = w;
		endcase
	endfunction : unit_sel

	// drop a received unit into its slot of the word
	function automatic logic [31:0] unit_put(input logic [31:0] w, input logic [31:0] u,
	                                          input logic [1:0] pk, input logic [1:0] ix);
		logic [31:0] r;
		r = w;
		case (pk)
			SPSH_WORD_ASSEMBLY_MODE_8:  r[{ix, 3'h0} +: 8] = u[7:0];
			SPSH_WORD_ASSEMBLY_MODE_16: r[{ix[0], 4'h0} +: 16] = u[15:0];
			default:      r = u;
		endcase
		unit_put = r;
	endfunction : unit_put

	// ----------------------------------------
	// system domain: apb registers
	// ----------------------------------------

	logic [31:0] ctl_q;        // serial_half_a_control
	logic [7:0]  div_q;        // sync_interval_divisor
	logic        err_q;        // sticky sync error
	logic        err_seen_q;   // last error toggle taken
	logic        pready_q;     // answer strobe
	logic [31:0] prdata_q;     // read data
	logic        pslverr_q;    // unmapped address
	logic        err_tog_s;    // error toggle, settled
	logic        tx_src_ready; // transmit path free
	logic        rx_dst_valid; // receive word waiting
	logic [31:0] rx_dst_data;
	logic [31:0] rd_data;      // read mux
	logic [31:0] stat_word;
	logic        miss;
	spsh_cfg_t   cfg_a;        // control fields in system domain

	// address decode
	wire hit_ctl  = (paddr == SPSH_CTL_OFF);
	wire hit_div  = (paddr == SPSH_DIV_OFF);
	wire hit_tx   = (paddr == SPSH_TX_OFF);
	wire hit_rx   = (paddr == SPSH_RX_OFF);
	wire hit_stat = (paddr == SPSH_STAT_OFF);
	wire acc      = psel & penable & ~pready_q;         // access not yet answered
	wire tx_req   = acc & pwrite & hit_tx;              // word offered to the link
	wire stall    = tx_req & ~tx_src_ready;             // hold pready while path busy
	wire done     = acc & ~stall;                       // answer next cycle
	wire wr_ok    = done & pwrite;
	wire rx_pop   = done & ~pwrite & hit_rx & rx_dst_valid;
	wire err_evt  = err_tog_s ^ err_seen_q;             // new sync error from the link
	wire err_clr  = wr_ok & hit_stat & pwdata[SPSH_ERR_POS];

	// status assembly
	always_comb begin
		stat_word = 32'h00000000;
		stat_word[SPSH_ERR_POS]   = err_q;
		stat_word[SPSH_TXRDY_POS] = tx_src_ready;
		stat_word[SPSH_RXVAL_POS] = rx_dst_valid;
	end

	// read mux and unmapped detection
	always_comb begin
		rd_data = 32'h00000000;
		miss    = 1'b0;
		if (hit_ctl) begin
			rd_data = ctl_q;
		end else if (hit_div) begin
			rd_data = {24'h000000, div_q};
		end else if (hit_tx) begin
			rd_data = 32'h00000000; // write only
		end else if (hit_rx) begin
			rd_data = rx_dst_valid ? rx_dst_data : 32'h00000000;
		end else if (hit_stat) begin
			rd_data = stat_word;
		end else begin
			miss = 1'b1;
		end
	end

	// control fields gathered for the link
	always_comb begin
		cfg_a.gated    = ctl_q[SPSH_GCLK_POS];
		cfg_a.discard  = ctl_q[SPSH_ERRM_POS];
		cfg_a.word_assembly_mode     = ctl_q[SPSH_WORD_ASSEMBLY_MODE_LO +: 2];
		cfg_a.late     = ctl_q[SPSH_LATE_POS];
		cfg_a.low      = ctl_q[SPSH_LOW_POS];
		cfg_a.indep    = ctl_q[SPSH_INDEP_POS];
		cfg_a.internal = ctl_q[SPSH_INT_POS];
		cfg_a.divisor  = div_q;
	end

	// register writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= SPSH_CTL_RST;
			div_q <= SPSH_DIV_RST;
		end else if (wr_ok && hit_ctl) begin
			ctl_q <= pwdata & SPSH_CTL_MASK;
		end else if (wr_ok && hit_div) begin
			div_q <= pwdata[7:0];
		end
	end

	// sticky error: a new event wins over a clear in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			err_q      <= 1'b0;
			err_seen_q <= 1'b0;
		end else begin
			err_q      <= err_evt | (err_q & ~err_clr);
			err_seen_q <= err_tog_s;
		end
	end

	// apb answer, one cycle after the access phase opens, later for a transmit write while the path is busy
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= done;
			prdata_q  <= (done && !pwrite) ? rd_data : 32'h00000000;
			pslverr_q <= done & miss;
		end
	end

	assign pready  = pready_q;
	assign prdata  = prdata_q;
	assign pslverr = pslverr_q;

	// ----------------------------------------
	// clock crossings
	// ----------------------------------------

	spsh_cfg_t   cfg;          // control fields, link domain
	logic        ext_lvl;      // sync pin, settled
	logic        err_tog_q;    // toggles once per sync error
	logic        tx_has;       // transmit word waiting at the link
	logic [31:0] tx_data;
	logic        tx_pop;
	logic        rx_room;      // receive path can take a word
	logic        rx_push;
	logic [31:0] asm_q;        // receive word under assembly

	spsh_sync #(.W($bits(spsh_cfg_t))) u_cfg (.clock(link_clk), .rst_n(rst_n), .d(cfg_a), .q(cfg));
	spsh_sync #(.W(1)) u_pin (.clock(link_clk), .rst_n(rst_n), .d(sync_i), .q(ext_lvl));
	spsh_sync #(.W(1)) u_err (.clock(clock), .rst_n(rst_n), .d(err_tog_q), .q(err_tog_s));

	// transmit words toward the link
	spsh_word_xfer u_tx (
		.src_clk   (clock),
		.dst_clk   (link_clk),
		.rst_n     (rst_n),
		.src_valid (tx_req),
		.src_ready (tx_src_ready),
		.src_data  (pwdata),
		.dst_valid (tx_has),
		.dst_ready (tx_pop),
		.dst_data  (tx_data)
	);

	// assembled receive words toward software
	spsh_word_xfer u_rx (
		.src_clk   (link_clk),
		.dst_clk   (clock),
		.rst_n     (rst_n),
		.src_valid (rx_push),
		.src_ready (rx_room),
		.src_data  (asm_q),
		.dst_valid (rx_dst_valid),
		.dst_ready (rx_pop),
		.dst_data  (rx_dst_data)
	);

	// ----------------------------------------
	// link domain: framing and shifting
	// ----------------------------------------

	spsh_state_t st_q, st_d;   // sequencer
	logic        ph_q;         // bit phase, high in second half
	logic [4:0]  bit_q, bit_d; // bits left in unit after this one
	logic [1:0]  idx_q, idx_d; // unit index in word
	logic        first_q, first_d;
	logic [7:0]  ivl_q;        // sync slot counter
	logic [31:0] sh_q, sh_d;   // transmit shifter
	logic [31:0] tw_q, tw_d;   // transmit word in use
	logic [31:0] rsh_q;        // receive shifter
	logic [31:0] asm_d;
	logic [31:0] word_src;
	logic [1:0]  idx_use;
	logic        ext_prev_q;   // sync level one cycle ago
	logic        ext_pend_q;   // sync edge waiting for bit boundary
	logic        ser_clk_q, sync_o_q, sync_oe_n_q, data_o_q;

	wire ext_act   = ext_lvl ^ cfg.low;
	wire ext_edge  = ext_act & ~ext_prev_q;                    // transition to active
	wire tick      = ph_q;                                     // bit boundary, clock falls
	wire busy      = (st_q != SPSH_IDLE);
	wire last_bit  = (st_q == SPSH_SHIFT) && (bit_q == 5'h00);
	wire slot      = tick && (ivl_q == 8'h00);
	wire int_go    = slot & (cfg.indep | tx_has | rx_room);
	wire go        = cfg.internal ? int_go : ext_pend_q;
	wire ferr      = tick & ~cfg.internal & ext_pend_q & (st_q == SPSH_SHIFT) & ~last_bit;
	wire restart   = ferr & cfg.discard;
	wire begin_fr  = tick & ((go & (~busy | last_bit)) | restart);
	wire sync_d    = (st_d == SPSH_LEAD) | ((st_d == SPSH_SHIFT) & first_d & cfg.late);
	wire run_d     = ~cfg.gated | (st_d != SPSH_IDLE);
	wire [7:0] rel = (cfg.divisor == 8'h00) ? 8'h00 : cfg.divisor - 8'h01;

	// sequencer next state
	always_comb begin
		st_d     = st_q;
		bit_d    = bit_q;
		idx_d    = idx_q;
		first_d  = first_q;
		sh_d     = sh_q;
		tw_d     = tw_q;
		asm_d    = asm_q;
		rx_push  = 1'b0;
		tx_pop   = 1'b0;
		word_src = tw_q;
		idx_use  = idx_q;
		if (tick) begin
			if (st_q == SPSH_SHIFT) begin
				// next bit, or close the unit on the last one
				bit_d   = bit_q - 5'h01;
				sh_d    = {sh_q[30:0], 1'b0};
				first_d = 1'b0;
				if (last_bit) begin
					asm_d = unit_put(asm_q, rsh_q, cfg.word_assembly_mode, idx_q);
					st_d  = SPSH_IDLE;
					if (idx_q == idx_last(cfg.word_assembly_mode)) begin
						rx_push = 1'b1;
						idx_d   = 2'h0;
					end else begin
						idx_d = idx_q + 2'h1;
					end
				end
			end else if (st_q == SPSH_LEAD) begin
				// lead bit over, data starts
				st_d    = SPSH_SHIFT;
				first_d = 1'b1;
			end
			if (begin_fr) begin
				// a sync error in discard mode throws away the partial word
				if (restart) begin
					asm_d = 32'h00000000;
					idx_d = 2'h0;
				end
				idx_use = idx_d;
				if (idx_use == 2'h0) begin
					word_src = tx_has ? tx_data : 32'h00000000;
					tx_pop   = tx_has;
					tw_d     = word_src;
				end
				sh_d  = unit_sel(word_src, cfg.word_assembly_mode, idx_use);
				bit_d = unit_last(cfg.word_assembly_mode);
				if (cfg.internal && !cfg.late) begin
					st_d    = SPSH_LEAD;
					first_d = 1'b0;
				end else begin
					st_d    = SPSH_SHIFT;
					first_d = 1'b1;
				end
			end
		end
	end

	// sequencer state
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= SPSH_IDLE;
			bit_q   <= 5'h00;
			idx_q   <= 2'h0;
			first_q <= 1'b0;
			sh_q    <= 32'h00000000;
			tw_q    <= 32'h00000000;
			asm_q   <= 32'h00000000;
		end else begin
			st_q    <= st_d;
			bit_q   <= bit_d;
			idx_q   <= idx_d;
			first_q <= first_d;
			sh_q    <= sh_d;
			tw_q    <= tw_d;
			asm_q   <= asm_d;
		end
	end

	// receive sampling on the rising serial clock, inside frames only
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsh_q <= 32'h00000000;
		end else if (!ph_q && (st_q == SPSH_SHIFT)) begin
			rsh_q <= {rsh_q[30:0], data_i};
		end
	end

	// bit phase, slot counter, pin edge and error toggle
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q       <= 1'b0;
			ivl_q      <= 8'h00;
			ext_prev_q <= 1'b0;
			ext_pend_q <= 1'b0;
			err_tog_q  <= 1'b0;
		end else begin
			ph_q       <= ~ph_q;
			ivl_q      <= !tick ? ivl_q : (ivl_q == 8'h00) ? rel : ivl_q - 8'h01;
			ext_prev_q <= ext_act;
			ext_pend_q <= ext_edge | (ext_pend_q & ~tick); // edge on a boundary waits one bit
			err_tog_q  <= err_tog_q ^ ferr;
		end
	end

	// pin drivers, all registered
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ser_clk_q   <= 1'b0;
			sync_o_q    <= 1'b0;
			sync_oe_n_q <= 1'b1;
			data_o_q    <= 1'b0;
		end else begin
			ser_clk_q   <= run_d & ~ph_q;
			sync_o_q    <= sync_d ^ cfg.low;
			sync_oe_n_q <= ~cfg.internal;
			data_o_q    <= sh_d[31];
		end
	end

	assign ser_clk_o = ser_clk_q;
	assign sync_o    = sync_o_q;
	assign sync_oe_n = sync_oe_n_q;
	assign data_o    = data_o_q;

endmodule : spsh_half_ctl

/* spsh_half_ctl_asserts.sv */
// spsh_half_ctl_asserts.sv: port checks for the serial half block
module spsh_half_ctl_asserts
	import spsh_pkg::*;
(
	// system side
	input logic        clock,
	input logic        rst_n,
	input logic [7:0]  paddr,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	// link side
	input logic        link_clk,
	input logic        ser_clk_o,
	input logic        sync_o,
	input logic        sync_oe_n
);
	// ------
	// config shadow
	// ------
	logic [31:0] ctl_q;  // last control write
	logic [7:0]  div_q;  // last divisor write
	logic [5:0]  age_q;  // since config write
	logic [7:0]  gap_q;  // link cycles since sync rise
	logic [7:0]  low_q;  // link cycles of clock low
	logic        seen_q; // gap valid
	logic        act_q;  // sync active last cycle
	wire         wr_cfg = pready && pwrite && !pslverr && paddr <= SPSH_DIV_OFF;
	wire         stl    = age_q == 6'h3F;
	wire         act    = sync_o ^ ctl_q[SPSH_LOW_POS];
	wire         intl   = ctl_q[SPSH_INT_POS];
	wire         rise   = act && !act_q;
	wire         mapped = paddr <= SPSH_STAT_OFF && paddr[1:0] == 2'h0;
	// shadow written with pready; age saturates
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= SPSH_CTL_RST;
			div_q <= SPSH_DIV_RST;
			age_q <= 6'h00;
		end else begin
			ctl_q <= (wr_cfg && paddr == SPSH_CTL_OFF) ? (pwdata & SPSH_CTL_MASK) : ctl_q;
			div_q <= (wr_cfg && paddr == SPSH_DIV_OFF) ? pwdata[7:0] : div_q;
			age_q <= wr_cfg ? 6'h00 : age_q + {5'h00, !stl};
		end
	end
	// link-side counters
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			{gap_q, low_q, seen_q, act_q} <= '0;
		end else begin
			act_q  <= act;
			low_q  <= ser_clk_o ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
			gap_q  <= rise ? 8'h01 : gap_q + {7'h00, gap_q != 8'hFF};
			seen_q <= stl && (seen_q || rise);
		end
	end
	// ------
	// checks
	// ------
	a_pready_single: assert property (@(posedge clock) disable iff (!rst_n) pready |=> !pready)
		else $error("pready too long");
	a_pready_latency: assert property (@(posedge clock) disable iff (!rst_n)
		psel && penable && !$past(penable) && paddr != SPSH_TX_OFF |=> pready)
		else $error("pready late");
	a_err_unmapped: assert property (@(posedge clock) disable iff (!rst_n) pready |-> pslverr == !mapped)
		else $error("pslverr wrong");
	a_read_idle: assert property (@(posedge clock) disable iff (!rst_n) !(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero");
	a_ctl_readback: assert property (@(posedge clock) disable iff (!rst_n)
		pready && !pwrite && paddr == SPSH_CTL_OFF |-> prdata == ctl_q)
		else $error("ctl readback wrong");
	a_pin_owner: assert property (@(posedge clock) disable iff (!rst_n) stl |-> sync_oe_n == !intl)
		else $error("sync drive wrong");
	a_sync_short: assert property (@(posedge link_clk) disable iff (!rst_n) stl && intl && act && act_q |=> !act)
		else $error("sync too long");
	a_sync_one_bit: assert property (@(posedge link_clk) disable iff (!rst_n) stl && intl && rise |=> act)
		else $error("sync too short");
	a_sync_period: assert property (@(posedge link_clk) disable iff (!rst_n)
		stl && intl && ctl_q[SPSH_INDEP_POS] && div_q >= 8'h22 && seen_q && rise |-> gap_q == {div_q, 1'b0})
		else $error("sync spacing wrong");
	a_free_clock: assert property (@(posedge link_clk) disable iff (!rst_n)
		stl && !ctl_q[SPSH_GCLK_POS] |-> ser_clk_o != $past(ser_clk_o))
		else $error("free clock stalled");
	a_gated_start: assert property (@(posedge link_clk) disable iff (!rst_n)
		stl && ctl_q[SPSH_GCLK_POS] && intl && ser_clk_o && low_q >= 8'h04 |-> act || act_q)
		else $error("gated clock early");
	a_gated_stop: assert property (@(posedge link_clk) disable iff (!rst_n)
		stl && ctl_q[SPSH_GCLK_POS] && intl && seen_q && ser_clk_o |-> gap_q <= 8'h48)
		else $error("gated clock late");
endmodule : spsh_half_ctl_asserts

/* spsh_codec_model.sv */
// spsh_codec_model.sv: converter on the far side of the link
module spsh_codec_model (
	// link timing
	input  logic       link_clk,
	input  logic       ser_clk,
	// pin levels
	input  logic       sync_pin,
	input  logic       data_o,
	// frame format, sync request
	input  logic       low,
	input  logic       late,
	input  logic [5:0] nbits,
	input  logic       ext_req,
	// driven back
	output logic       sync_drv,
	output logic       data_i
);
	logic [31:0] units[$]; // completed units, oldest first
	logic [31:0] sh;       // unit being collected
	logic [5:0]  cnt;      // bits still to collect
	logic [1:0]  hold;     // link cycles of sync left
	logic        req_q;    // last request level
	logic        toggle;   // changing filler outside frames
	wire         act = sync_pin ^ low;
	assign sync_drv = low ^ (hold != 2'h0);
	assign data_i   = (act || cnt != 6'h0) ? data_o : toggle;
	initial {sh, cnt, hold, req_q, toggle} = '0;
	// request toggle: one-bit sync pulse
	always @(posedge link_clk) begin
		toggle <= ~toggle;
		req_q  <= ext_req;
		hold   <= (ext_req != req_q) ? 2'h2 : hold - {1'b0, hold != 2'h0};
	end
	// collect units msb first
	always @(posedge ser_clk) begin
		if (cnt != 6'h0) begin
			sh  = {sh[30:0], data_o};
			cnt = cnt - 6'h1;
			if (cnt == 6'h0) units.push_back(sh);
		end else if (act) begin
			sh  = late ? {31'h0, data_o} : 32'h0;
			cnt = late ? nbits - 6'h1 : nbits;
		end
	end
endmodule : spsh_codec_model

/* tb.sv */
// tb.sv: bench for the serial half block
module tb
	import spsh_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// ------
	// signals
	// ------
	logic        clock, link_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        ser_clk_o, sync_o, sync_oe_n, data_o, data_i, sync_drv, low_m, late_m, ext_req, er;
	logic [7:0]  paddr;
	logic [5:0]  nbits_m;
	logic [31:0] pwdata, prdata, lfsr_q, rd, w, ctl;
	int          failures, samples_checked, k, j, n, nb;
	wire         sync_i = sync_oe_n ? sync_drv : sync_o; // resolved pin level
	always #10 clock = ~clock;
	initial #3.3 forever #16 link_clk = ~link_clk;
	spsh_half_ctl uut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.link_clk, .ser_clk_o, .sync_i, .sync_o, .sync_oe_n, .data_i, .data_o);
	spsh_codec_model m (.link_clk, .ser_clk(ser_clk_o), .sync_pin(sync_i), .data_o, .low(low_m), .late(late_m),
		.nbits(nbits_m), .ext_req, .sync_drv, .data_i);
	// ------
	// helpers
	// ------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// unit i of a word, low unit first
	function automatic logic [31:0] unit_of(input logic [31:0] v, input int b, input int i);
		return 32'((64'(v) >> (i * b)) & ((64'h1 << b) - 64'h1));
	endfunction : unit_of
	// first nonzero unit, 1000 if none
	function automatic int first_nz();
		foreach (m.units[i]) if (m.units[i] != 32'h0) return i;
		return 1000;
	endfunction : first_nz
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int c = 0;
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
		@(posedge clock);
		penable <= 1'h1;
		do @(posedge clock); while (pready !== 1'h1 && ++c < 4000);
		failures += int'(c == 4000);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic setup(input logic [31:0] c, input logic [5:0] b);
		apb(SPSH_DIV_OFF, 1'h1, 32'h28, rd, er);
		apb(SPSH_CTL_OFF, 1'h1, c, rd, er);
		{low_m, late_m, nbits_m} <= {c[SPSH_LOW_POS], c[SPSH_LATE_POS], b};
		repeat (100) @(posedge clock);
	endtask : setup
	task automatic pulse(input int gap);
		@(posedge link_clk);
		ext_req <= ~ext_req;
		repeat (gap) @(posedge link_clk);
	endtask : pulse
	task automatic end_sim();
		if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	// ------
	// main sequence
	// ------
	initial begin
		{clock, link_clk, rst_n, psel, penable, pwrite, low_m, late_m, ext_req, paddr, pwdata} = '0;
		{failures, samples_checked, nbits_m, lfsr_q} = {32'h0, 32'h0, 6'h08, 32'h1F3C43EC};
		repeat (20) @(posedge clock);
		rst_n <= 1'h1;
		apb(SPSH_CTL_OFF, 1'h0, 32'h0, rd, er);
		chk("ctl reset", SPSH_CTL_RST, rd);
		apb(SPSH_DIV_OFF, 1'h0, 32'h0, rd, er);
		chk("div reset", {24'h0, SPSH_DIV_RST}, rd);
		apb(8'h14, 1'h1, lfsr_q, rd, er);
		chk("unmapped wr err", 32'h1, {31'h0, er});
		apb(8'h14, 1'h0, 32'h0, rd, er);
		chk("unmapped rd", 32'h0, rd);
		chk("unmapped rd err", 32'h1, {31'h0, er});
		// random control, code 3 avoided
		for (k = 0; k < 6; k++) begin
			lfsr_q = lfsr(lfsr_q);
			ctl = lfsr_q & SPSH_CTL_MASK & ~{12'h0, lfsr_q[18], 19'h0};
			apb(SPSH_CTL_OFF, 1'h1, ctl, rd, er);
			apb(SPSH_CTL_OFF, 1'h0, 32'h0, rd, er);
			chk("ctl readback", ctl, rd);
		end
		// each assembly width, internal sync
		for (k = 0; k < 3; k++) begin
			ctl = 32'h0000C000 | (k << SPSH_WORD_ASSEMBLY_MODE_LO) | ((k == 1) << SPSH_LATE_POS) | ((k == 2) << SPSH_LOW_POS)
				| ((k != 0) << SPSH_GCLK_POS);
			nb = (k == 0) ? 32 : 8 * k;
			setup(ctl, 6'(nb));
			m.units.delete();
			lfsr_q = lfsr(lfsr_q);
			w = lfsr_q | 32'h01010101;
			apb(SPSH_TX_OFF, 1'h1, w, rd, er);
			n = 0;
			while (first_nz() + 32 / nb > m.units.size() && n < 30000) begin
				@(posedge link_clk);
				n++;
			end
			for (j = 0; j < 32 / nb; j++) chk("serial unit", unit_of(w, nb, j), m.units[first_nz() + j]);
		end
		// external sync errors in both modes
		for (k = 0; k < 2; k++) begin
			setup(32'h00050000 | (k << SPSH_ERRM_POS), 6'h08);
			apb(SPSH_STAT_OFF, 1'h1, 32'h1, rd, er);
			pulse(40);
			apb(SPSH_STAT_OFF, 1'h0, 32'h0, rd, er);
			chk("clean frame", 32'h0, rd & 32'h1);
			pulse(10);
			pulse(40);
			apb(SPSH_STAT_OFF, 1'h0, 32'h0, rd, er);
			chk("sync error", 32'h1, rd & 32'h1);
			apb(SPSH_STAT_OFF, 1'h1, 32'h1, rd, er);
			apb(SPSH_STAT_OFF, 1'h0, 32'h0, rd, er);
			chk("error cleared", 32'h0, rd & 32'h1);
		end
		end_sim();
	end
	// watchdog against a hang
	initial begin
		#1000000;
		failures++;
		end_sim();
	end
endmodule : tb

bind spsh_half_ctl spsh_half_ctl_asserts u_chk (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .pready, .pslverr, .link_clk, .ser_clk_o, .sync_o, .sync_oe_n);
